// file: logic/ppo_pin_sync.sv
// Two-stage pin input synchroniser with edge detection for one port.
// Assumes the input vector is asynchronous to ref_clk; the first stage is read only
// by the second.
`timescale 1ns/1ns

module ppo_pin_sync (
    input  wire logic                    ref_clk,
    input  wire logic                    rstn,
    input  wire logic [ppo_pkg::PINS-1:0] asyncIn,
    input  wire ppo_pkg::ppo_sense_e     sense,
    output logic      [ppo_pkg::PINS-1:0] syncOut,
    output logic      [ppo_pkg::PINS-1:0] edgeEvent
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ppo_pkg::ppo_sync_s st_q;
    ppo_pkg::ppo_sync_s st_d;

    // Shift the pin value along; the first stage stands for the sampling latch
    always_comb begin
        st_d        = st_q;
        st_d.stage1 = asyncIn;
        st_d.stage2 = st_q.stage1;
        st_d.prev   = st_q.stage2;
        st_d.warm   = (st_q.warm == ppo_pkg::SYNC_ARMED) ? st_q.warm : st_q.warm + 2'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Edge selection works on settled values only, never on the first stage
    always_comb begin
        case (sense)
            ppo_pkg::SENSE_RISE: edgeEvent = st_q.stage2 & ~st_q.prev;
            ppo_pkg::SENSE_FALL: edgeEvent = ~st_q.stage2 & st_q.prev;
            ppo_pkg::SENSE_ANY:  edgeEvent = st_q.stage2 ^ st_q.prev;
            default:             edgeEvent = '0;
        endcase
        // Stages restart at zero, so a high pin would fake a rising edge after reset
        if (st_q.warm != ppo_pkg::SYNC_ARMED) begin
            edgeEvent = '0;
        end
    end

    assign syncOut = st_q.stage2;

endmodule // ppo_pin_sync

// file: logic/ppo_pkg.sv
// Shared constants and types for the port pin override and sleep clamp block.
// Assumes one eight-pin port, reached over a 32-bit Avalon-MM slave with byte addresses.
package ppo_pkg;

    // ------------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------------
    localparam int PINS = 8;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_LATCH  = 5'h00; // Output latch, read/write
    localparam logic [ADDR_W-1:0] OFS_DIR    = 5'h04; // Direction, read/write
    localparam logic [ADDR_W-1:0] OFS_PIN    = 5'h08; // Pin input read, write one toggles
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h0c; // Edge sense selection
    localparam logic [ADDR_W-1:0] OFS_EXTEN  = 5'h10; // External request enable per pin
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14; // Sticky edge flags, read only
    localparam logic [ADDR_W-1:0] OFS_INTEN  = 5'h18; // Interrupt enable per pin
    localparam logic [ADDR_W-1:0] OFS_INTCLR = 5'h1c; // Write one to clear a flag

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_SENSE_LSB = 0;
    localparam int CTRL_SENSE_W = 2;
    localparam logic [PINS-1:0] RST_BYTE = 8'h00;
    localparam logic [1:0] SYNC_ARMED = 2'h3; // Clocks out of reset before edges count

    // ------------------------------------------------------------------
    // Enumerations and state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SENSE_RISE, SENSE_FALL, SENSE_ANY, SENSE_NONE} ppo_sense_e;
    typedef enum logic {BUS_IDLE, BUS_ACK} ppo_bus_e;

    typedef struct packed {
        ppo_bus_e          bus;
        logic              waitReq;
        logic [DATA_W-1:0] readData;
        logic [PINS-1:0]   latch;
        logic [PINS-1:0]   dir;
        logic [PINS-1:0]   extIntEn;
        logic [PINS-1:0]   intEnable;
        logic [PINS-1:0]   status;
        ppo_sense_e        sense;
        logic [PINS-1:0]   padOe;
        logic [PINS-1:0]   padOut;
        logic [PINS-1:0]   padPullup;
        logic              irq;
    } ppo_state_s;

    typedef struct packed {
        logic [PINS-1:0] stage1;
        logic [PINS-1:0] stage2;
        logic [PINS-1:0] prev;
        logic [1:0]      warm;
    } ppo_sync_s;

endpackage

// file: logic/ppo_port_pin.sv
// One eight-pin port: latch, direction, pin input, override muxing and sleep clamp.
// Assumes override signals and sleep control come from logic on ref_clk, and the pad
// level arrives asynchronously; a testbench resolves the pad wire from the enables.
`timescale 1ns/1ns

// Operation
// - Digital input is clamped low ahead of the trigger while sleep control is high.
// - Pins with external request enabled bypass the sleep clamp.
// - Clamp release on a high pin sets its edge flag under rise or any sense, even when interrupt disabled.
// - Pull-up follows override value when enabled, else on when dir/latch/disable 010.
// - Output enable follows direction override when enabled, else the direction bit.
// - Driven level follows value override when enabled, else the output latch.
// - Toggle override high inverts that pin's output latch bit.
// - Input-enable override sets digital input enable regardless of sleep state.
// - Alternate functions get the unsynchronised trigger output; they synchronise it.
// - Analog connection goes straight to the pad, bypassing digital buffering.
// - Strobes shared per port; clock, sleep, pull-up disable shared; overrides per pin.
// - Inputs stay enabled without clamp in reset, active and idle modes.
// - Pull-ups are off while reset is active; software may enable them later.
// - Direction one drives the latch; zero is input with latch-controlled pull-up.
// - Writing one to the pin input register toggles the latch bit; zero does nothing.
// - Pin value is sampled, then captured into the readable input bit next edge.
// - All pins go high impedance as soon as reset is asserted.
module ppo_port_pin (
    input  wire logic                       ref_clk,
    input  wire logic                       rstn,
    // Avalon-MM slave
    input  wire logic [ppo_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [3:0]                 avs_byteenable,
    input  wire logic [ppo_pkg::DATA_W-1:0] avs_writedata,
    output logic      [ppo_pkg::DATA_W-1:0] avs_readdata,
    output logic                            avs_waitrequest,
    // System wide controls
    input  wire logic                       sleepCtrl,
    input  wire logic                       globalPullupDisable,
    // Per pin overrides from alternate functions
    input  wire logic [ppo_pkg::PINS-1:0]   pullupOverrideEn,
    input  wire logic [ppo_pkg::PINS-1:0]   pullupOverrideVal,
    input  wire logic [ppo_pkg::PINS-1:0]   dirOverrideEn,
    input  wire logic [ppo_pkg::PINS-1:0]   dirOverrideVal,
    input  wire logic [ppo_pkg::PINS-1:0]   valueOverrideEn,
    input  wire logic [ppo_pkg::PINS-1:0]   valueOverrideVal,
    input  wire logic [ppo_pkg::PINS-1:0]   toggleOverrideEn,
    input  wire logic [ppo_pkg::PINS-1:0]   inputEnableOverrideEn,
    input  wire logic [ppo_pkg::PINS-1:0]   inputEnableOverrideVal,
    output logic      [ppo_pkg::PINS-1:0]   altfuncDigitalIn,
    output logic      [ppo_pkg::PINS-1:0]   altfuncAnalogIo,
    // Pads
    input  wire logic [ppo_pkg::PINS-1:0]   padIn,
    output logic      [ppo_pkg::PINS-1:0]   padOut,
    output logic      [ppo_pkg::PINS-1:0]   padOe,
    output logic      [ppo_pkg::PINS-1:0]   padPullup,
    output logic                            irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam ppo_pkg::ppo_state_s ST_RESET = '{
        bus:       ppo_pkg::BUS_IDLE,
        waitReq:   1'b1,
        readData:  32'h0000_0000,
        latch:     ppo_pkg::RST_BYTE,
        dir:       ppo_pkg::RST_BYTE,
        extIntEn:  ppo_pkg::RST_BYTE,
        intEnable: ppo_pkg::RST_BYTE,
        status:    ppo_pkg::RST_BYTE,
        sense:     ppo_pkg::SENSE_RISE,
        padOe:     ppo_pkg::RST_BYTE,
        padOut:    ppo_pkg::RST_BYTE,
        padPullup: ppo_pkg::RST_BYTE,
        irq:       1'b0
    };

    ppo_pkg::ppo_state_s          st_q;
    ppo_pkg::ppo_state_s          st_d;
    logic [ppo_pkg::PINS-1:0]     inputEnable;
    logic [ppo_pkg::PINS-1:0]     clampedIn;
    logic [ppo_pkg::PINS-1:0]     pinSync;
    logic [ppo_pkg::PINS-1:0]     edgeEvent;
    logic                         busTake;
    logic                         wrTake;
    logic [ppo_pkg::PINS-1:0]     wrByte;
    logic                         writeLatchStrobe;
    logic                         writeInputRegStrobe;
    logic                         writeDirectionStrobe;
    logic                         writeCtrlStrobe;
    logic                         writeExtEnStrobe;
    logic                         writeIntEnStrobe;
    logic                         writeIntClrStrobe;

    // ------------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------------
    // Unmapped offsets and the write-only clear register read as zero
    function automatic logic [ppo_pkg::DATA_W-1:0] regRead(
        input logic [ppo_pkg::ADDR_W-1:0] addr,
        input ppo_pkg::ppo_state_s        s,
        input logic [ppo_pkg::PINS-1:0]   pins
    );
        logic [ppo_pkg::PINS-1:0] v;
        v = '0;
        case (addr)
            ppo_pkg::OFS_LATCH:  v = s.latch;
            ppo_pkg::OFS_DIR:    v = s.dir;
            ppo_pkg::OFS_PIN:    v = pins;
            ppo_pkg::OFS_CTRL:   v = {6'h00, s.sense};
            ppo_pkg::OFS_EXTEN:  v = s.extIntEn;
            ppo_pkg::OFS_STATUS: v = s.status;
            ppo_pkg::OFS_INTEN:  v = s.intEnable;
            default:             v = '0;
        endcase
        return {24'h00_0000, v};
    endfunction

    // ------------------------------------------------------------------
    // Input path: enable, clamp and alternate function taps
    // ------------------------------------------------------------------
    // Sleep clamp gates the pad ahead of the trigger; reset keeps inputs alive
    always_comb begin
        inputEnable = (inputEnableOverrideEn & inputEnableOverrideVal)
                    | (~inputEnableOverrideEn
                       & ({ppo_pkg::PINS{~sleepCtrl | ~rstn}}
                          | st_q.extIntEn));
        clampedIn   = padIn & inputEnable;
    end

    // Taken before the synchroniser; receivers synchronise it themselves
    assign altfuncDigitalIn = clampedIn;
    // Pass-through of the pad level; the true analog wire is outside the logic
    assign altfuncAnalogIo  = padIn;

    // Pin input register and edge flags; clamp release shows up as an edge here
    ppo_pin_sync u_sync (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .asyncIn   (clampedIn),
        .sense     (st_q.sense),
        .syncOut   (pinSync),
        .edgeEvent (edgeEvent)
    );

    // ------------------------------------------------------------------
    // Bus strobes
    // ------------------------------------------------------------------
    // One strobe per writable register, common to all pins of the port
    always_comb begin
        busTake              = (st_q.bus == ppo_pkg::BUS_ACK) && !st_q.waitReq
                             && (avs_read || avs_write);
        wrTake               = busTake && avs_write && avs_byteenable[0];
        wrByte               = avs_writedata[ppo_pkg::PINS-1:0];
        writeLatchStrobe     = wrTake && (avs_address == ppo_pkg::OFS_LATCH);
        writeInputRegStrobe  = wrTake && (avs_address == ppo_pkg::OFS_PIN);
        writeDirectionStrobe = wrTake && (avs_address == ppo_pkg::OFS_DIR);
        writeCtrlStrobe      = wrTake && (avs_address == ppo_pkg::OFS_CTRL);
        writeExtEnStrobe     = wrTake && (avs_address == ppo_pkg::OFS_EXTEN);
        writeIntEnStrobe     = wrTake && (avs_address == ppo_pkg::OFS_INTEN);
        writeIntClrStrobe    = wrTake && (avs_address == ppo_pkg::OFS_INTCLR);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;

        // Every access waits exactly one cycle; read data is fixed at the first edge
        case (st_q.bus)
            ppo_pkg::BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    st_d.bus      = ppo_pkg::BUS_ACK;
                    st_d.waitReq  = 1'b0;
                    st_d.readData = avs_read ? regRead(avs_address, st_q, pinSync)
                                             : st_q.readData;
                end
            end
            ppo_pkg::BUS_ACK: begin
                st_d.bus     = ppo_pkg::BUS_IDLE;
                st_d.waitReq = 1'b1;
            end
            default: begin
                st_d.bus     = ppo_pkg::BUS_IDLE;
                st_d.waitReq = 1'b1;
            end
        endcase

        // Output latch: write, pin-register toggle, then override toggle
        if (writeLatchStrobe) begin
            st_d.latch = wrByte;
        end
        if (writeInputRegStrobe) begin
            st_d.latch = st_q.latch ^ wrByte;
        end
        st_d.latch = st_d.latch ^ toggleOverrideEn;

        // Plain control registers
        if (writeDirectionStrobe) begin
            st_d.dir = wrByte;
        end
        if (writeCtrlStrobe) begin
            st_d.sense = ppo_pkg::ppo_sense_e'(
                wrByte[ppo_pkg::CTRL_SENSE_LSB +: ppo_pkg::CTRL_SENSE_W]);
        end
        if (writeExtEnStrobe) begin
            st_d.extIntEn = wrByte;
        end
        if (writeIntEnStrobe) begin
            st_d.intEnable = wrByte;
        end

        // A flag raised in the clearing cycle survives the clear
        st_d.status = (st_q.status & ~(writeIntClrStrobe ? wrByte : ppo_pkg::RST_BYTE))
                    | edgeEvent;
        st_d.irq    = |(st_d.status & st_d.intEnable);

        // Pad drivers registered from current settings, one cycle behind
        st_d.padOe     = (dirOverrideEn & dirOverrideVal)
                       | (~dirOverrideEn & st_q.dir);
        st_d.padOut    = (valueOverrideEn & valueOverrideVal)
                       | (~valueOverrideEn & st_q.latch);
        st_d.padPullup = (pullupOverrideEn & pullupOverrideVal)
                       | (~pullupOverrideEn & ~st_q.dir & st_q.latch
                          & {ppo_pkg::PINS{~globalPullupDisable}});
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Reset gates the drivers directly so pads float without waiting for a clock
    assign padOe           = st_q.padOe & {ppo_pkg::PINS{rstn}};
    assign padPullup       = st_q.padPullup & {ppo_pkg::PINS{rstn}};
    assign padOut          = st_q.padOut;
    assign avs_readdata    = st_q.readData;
    assign avs_waitrequest = st_q.waitReq;
    assign irq             = st_q.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    a_clamp_in_sleep: assert property (
        (sleepCtrl && inputEnableOverrideEn == 8'h00 && st_q.extIntEn == 8'h00)
            |-> (altfuncDigitalIn == 8'h00))
        else $error("digital input not clamped in sleep");

    a_extint_bypass: assert property (
        (sleepCtrl && inputEnableOverrideEn == 8'h00)
            |-> ((altfuncDigitalIn & st_q.extIntEn) == (padIn & st_q.extIntEn)))
        else $error("external request pin clamped in sleep");

    a_pullup_mux: assert property (
        $past(rstn) |-> (padPullup == (($past(pullupOverrideEn) & $past(pullupOverrideVal))
            | (~$past(pullupOverrideEn) & ~$past(st_q.dir) & $past(st_q.latch)
               & {8{~$past(globalPullupDisable)}}))))
        else $error("pull-up enable wrong");

    a_oe_mux: assert property (
        $past(rstn) |-> (padOe == (($past(dirOverrideEn) & $past(dirOverrideVal))
            | (~$past(dirOverrideEn) & $past(st_q.dir)))))
        else $error("output enable wrong");

    a_value_mux: assert property (
        $past(rstn) |-> (padOut == (($past(valueOverrideEn) & $past(valueOverrideVal))
            | (~$past(valueOverrideEn) & $past(st_q.latch)))))
        else $error("driven value wrong");

    a_toggle_latch: assert property (
        (!writeLatchStrobe && !writeInputRegStrobe)
            |=> (st_q.latch == ($past(st_q.latch) ^ $past(toggleOverrideEn))))
        else $error("latch toggle wrong");

    a_pin_write_toggle: assert property (
        writeInputRegStrobe
            |=> (st_q.latch == ($past(st_q.latch) ^ $past(wrByte) ^ $past(toggleOverrideEn))))
        else $error("pin register write did not toggle latch");

    a_ie_override: assert property (
        (altfuncDigitalIn & inputEnableOverrideEn)
            == (padIn & inputEnableOverrideEn & inputEnableOverrideVal))
        else $error("input enable override ignored");

    a_pin_sample: assert property (
        $past(rstn, 2) |-> (pinSync == $past(clampedIn, 2)))
        else $error("pin input register not two stages behind");

    a_bus_one_wait: assert property (
        ((avs_read || avs_write) && avs_waitrequest && st_q.bus == ppo_pkg::BUS_IDLE)
            |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not one cycle");

    a_irq_level: assert property (
        irq == |(st_q.status & st_q.intEnable))
        else $error("interrupt level wrong");

    a_flag_sticky: assert property (
        (|edgeEvent) |=> ((st_q.status & $past(edgeEvent)) == $past(edgeEvent)))
        else $error("edge flag lost");

    // Reset-time checks lift the default disable
    a_float_in_reset: assert property (
        disable iff (1'b0) !rstn |-> (padOe == 8'h00 && padPullup == 8'h00))
        else $error("pad driven or pulled in reset");

    a_input_in_reset: assert property (
        disable iff (1'b0) (!rstn && inputEnableOverrideEn == 8'h00) |-> (altfuncDigitalIn == padIn))
        else $error("digital input blocked in reset");

    a_analog_wire: assert property (
        altfuncAnalogIo == padIn)
        else $error("analog tap differs from pad");

    // Register writes land at the accepting edge
    a_dir_write: assert property (
        writeDirectionStrobe |=> (st_q.dir == $past(wrByte)))
        else $error("direction write lost");

    a_clear_works: assert property (
        writeIntClrStrobe |=> ((st_q.status & $past(wrByte) & ~$past(edgeEvent)) == 8'h00))
        else $error("flag survived its clear");

    c_sleep_clamp:  cover property (sleepCtrl && padIn != 8'h00 && altfuncDigitalIn == 8'h00);
    c_wake_flag:    cover property (sleepCtrl ##1 !sleepCtrl ##[1:4] (|edgeEvent));
    c_pin_toggle:   cover property (writeInputRegStrobe);
    c_irq_raised:   cover property (!irq ##1 irq);
    c_pullup_ovr:   cover property (|(pullupOverrideEn & pullupOverrideVal));

endmodule // ppo_port_pin

// file: test/ppo_altfunc_model.sv
// Stand-in for the alternate-function modules that sit on the far side of one port.
// Assumes the bench selects one override kind at a time and which pins are owned.
`timescale 1ns/1ns

module ppo_altfunc_model (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic [2:0] modeSel,
    input  wire logic [7:0] ownMask,
    input  wire logic [7:0] ovVal,
    input  wire logic [7:0] digitalIn,
    output logic      [7:0] puEn,
    output logic      [7:0] puVal,
    output logic      [7:0] dirEn,
    output logic      [7:0] dirVal,
    output logic      [7:0] valEn,
    output logic      [7:0] valVal,
    output logic      [7:0] togEn,
    output logic      [7:0] ieEn,
    output logic      [7:0] ieVal,
    output logic      [7:0] syncedIn
);
    logic [2:0] modeQ;
    logic [7:0] syncA;
    // Raw input is asynchronous here, so it gets its own two flops
    always_ff @(posedge ref_clk) begin
        modeQ    <= rstn ? modeSel : 3'h0;
        syncA    <= digitalIn;
        syncedIn <= syncA;
    end
    // Enables only on owned pins, all others held inactive
    assign puEn   = (modeSel == 3'h1) ? ownMask : 8'h00;
    assign dirEn  = (modeSel == 3'h2) ? ownMask : 8'h00;
    assign valEn  = (modeSel == 3'h3) ? ownMask : 8'h00;
    assign ieEn   = (modeSel == 3'h5) ? ownMask : 8'h00;
    // Toggle is a level per cycle in the port, so only one cycle is sent
    assign togEn  = (modeSel == 3'h4 && modeQ != 3'h4) ? (ownMask & ovVal) : 8'h00;
    assign puVal  = ovVal;
    assign dirVal = ovVal;
    assign valVal = ovVal;
    assign ieVal  = ovVal;
endmodule // ppo_altfunc_model

// file: test/test_ppo_port_pin.sv
// Self-checking bench for the port pin override and sleep clamp block.
// Assumes a pad level source on every pin; the pad wire is resolved from padOe here.
`timescale 1ns/1ns

module test_ppo_port_pin;
    logic        ref_clk, rstn, sleepCtrl, gpd, avsRead, avsWrite, avsWait;
    logic [4:0]  avsAddr;
    logic [31:0] avsWdata, avsRdata, rdv;
    logic [7:0]  ownMask, ovVal, extLevel, padIn, padOut, padOe, padPullup, altDi, altAio;
    logic [7:0]  puEn, puVal, dirEn, dirVal, valEn, valVal, togEn, ieEn, ieVal, syncedIn;
    logic [7:0]  eL, eD, eO;
    logic [2:0]  modeSel;
    logic        irq;
    int          errors, comparisons, cycles;

    // Undriven pins take the external level; pull-ups lose to it
    assign padIn = (padOe & padOut) | (~padOe & extLevel);
    always #5 ref_clk = ~ref_clk;

    ppo_port_pin dut_u (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avsAddr),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_byteenable(4'h1),
        .avs_writedata(avsWdata), .avs_readdata(avsRdata), .avs_waitrequest(avsWait),
        .sleepCtrl(sleepCtrl), .globalPullupDisable(gpd), .pullupOverrideEn(puEn),
        .pullupOverrideVal(puVal), .dirOverrideEn(dirEn), .dirOverrideVal(dirVal),
        .valueOverrideEn(valEn), .valueOverrideVal(valVal), .toggleOverrideEn(togEn),
        .inputEnableOverrideEn(ieEn), .inputEnableOverrideVal(ieVal),
        .altfuncDigitalIn(altDi), .altfuncAnalogIo(altAio), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .padPullup(padPullup), .irq(irq));

    ppo_altfunc_model peer_u (.ref_clk(ref_clk), .rstn(rstn), .modeSel(modeSel),
        .ownMask(ownMask), .ovVal(ovVal), .digitalIn(altDi), .puEn(puEn), .puVal(puVal),
        .dirEn(dirEn), .dirVal(dirVal), .valEn(valEn), .valVal(valVal), .togEn(togEn),
        .ieEn(ieEn), .ieVal(ieVal), .syncedIn(syncedIn));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until waitrequest is sampled low at an edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        avsAddr  <= a;
        avsRead  <= ~wr;
        avsWrite <= wr;
        avsWdata <= {24'h000000, d};
        do @(posedge ref_clk); while (avsWait !== 1'b0);
        rdv = avsRdata;
        avsRead  <= 1'b0;
        avsWrite <= 1'b0;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(rdv, {24'h000000, exp});
    endtask

    task automatic final_report;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Hang guard, well above the length of the sequence below
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0; rstn = 1'b0; sleepCtrl = 1'b1; gpd = 1'b0; modeSel = 3'h0;
        ownMask = 8'h00; ovVal = 8'h00; extLevel = 8'hff; avsAddr = 5'h00;
        avsRead = 1'b0; avsWrite = 1'b0; avsWdata = 32'h00000000;
        errors = 0; comparisons = 0; cycles = 0;
        repeat (19) @(posedge ref_clk);
        check(altDi, 8'hff);
        check({padOe, padPullup}, 16'h0000);
        sleepCtrl <= 1'b0;
        @(posedge ref_clk);
        rstn <= 1'b1;
        rdchk(ppo_pkg::OFS_LATCH, 8'h00);
        bus(1'b1, ppo_pkg::OFS_LATCH, 8'ha5);
        bus(1'b1, ppo_pkg::OFS_DIR, 8'h0f);
        repeat (3) @(posedge ref_clk);
        rdchk(ppo_pkg::OFS_PIN, 8'hf5);
        // Each override kind on a part of the port only
        ownMask <= 8'h3c;
        ovVal   <= 8'h99;
        for (int m = 0; m < 4; m++) begin
            modeSel <= m[2:0];
            repeat (3) @(posedge ref_clk);
            eL = (m == 1) ? (8'h18 | (8'hc3 & 8'ha0)) : 8'ha0;
            eD = (m == 2) ? (8'h18 | (8'hc3 & 8'h0f)) : 8'h0f;
            eO = (m == 3) ? (8'h18 | (8'hc3 & 8'ha5)) : 8'ha5;
            check({padPullup, padOe, padOut}, {eL, eD, eO});
        end
        modeSel <= 3'h0;
        gpd     <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(padPullup, 8'h00);
        gpd     <= 1'b0;
        modeSel <= 3'h4;
        repeat (3) @(posedge ref_clk);
        modeSel <= 3'h0;
        rdchk(ppo_pkg::OFS_LATCH, 8'hbd);
        bus(1'b1, ppo_pkg::OFS_PIN, 8'h03);
        rdchk(ppo_pkg::OFS_LATCH, 8'hbe);
        // Sleep clamp, its bypass and the input-enable override
        sleepCtrl <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check({altDi, altAio}, 16'h00fe);
        bus(1'b1, ppo_pkg::OFS_EXTEN, 8'h30);
        repeat (2) @(posedge ref_clk);
        check(altDi, 8'h30);
        modeSel <= 3'h5;
        repeat (2) @(posedge ref_clk);
        check(altDi, 8'h18);
        modeSel <= 3'h0;
        bus(1'b1, ppo_pkg::OFS_EXTEN, 8'h00);
        bus(1'b1, ppo_pkg::OFS_DIR, 8'h00);
        repeat (6) @(posedge ref_clk);
        bus(1'b1, ppo_pkg::OFS_INTCLR, 8'hff);
        rdchk(ppo_pkg::OFS_STATUS, 8'h00);
        // Waking with every pin high gives a rising edge on all of them
        sleepCtrl <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rdchk(ppo_pkg::OFS_STATUS, 8'hff);
        check(irq, 1'b0);
        bus(1'b1, ppo_pkg::OFS_INTEN, 8'h01);
        repeat (2) @(posedge ref_clk);
        check(irq, 1'b1);
        bus(1'b1, ppo_pkg::OFS_INTEN, 8'h00);
        repeat (2) @(posedge ref_clk);
        check(irq, 1'b0);
        bus(1'b1, ppo_pkg::OFS_INTEN, 8'h01);
        bus(1'b1, ppo_pkg::OFS_INTCLR, 8'h01);
        repeat (2) @(posedge ref_clk);
        check(irq, 1'b0);
        rdchk(ppo_pkg::OFS_STATUS, 8'hfe);
        rdchk(ppo_pkg::OFS_INTCLR, 8'h00);
        rdchk(5'h02, 8'h00);
        // Reset in mid-run floats driven pins at once
        bus(1'b1, ppo_pkg::OFS_DIR, 8'hff);
        repeat (3) @(posedge ref_clk);
        check(padOe, 8'hff);
        rstn <= 1'b0;
        #1;
        check({padOe, padPullup}, 16'h0000);
        final_report();
    end
endmodule // test_ppo_port_pin
